// ---- verilog/rwsc_pkg.sv ----
/*
 * Constants, field positions and types of the reset and wake state control.
 * Assumes an 8-bit core register space reached by a plain strobe port.
 */
package rwsc_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] RWSC_ADDR_STATUS = 8'h03;
	localparam logic [7:0] RWSC_ADDR_INTCTL = 8'h0b;
	localparam logic [7:0] RWSC_ADDR_PFLAG = 8'h0c;
	localparam logic [7:0] RWSC_ADDR_PEN = 8'h8c;
	localparam logic [7:0] RWSC_ADDR_CAUSE = 8'h8e;
	localparam logic [7:0] RWSC_ADDR_EVSTAT = 8'h40;
	localparam logic [7:0] RWSC_ADDR_EVMASK = 8'h41;

	// ------------------------------------------------------------
	// Field positions and values
	// ------------------------------------------------------------
	localparam int RWSC_ST_TO = 4;
	localparam int RWSC_ST_PD = 3;
	localparam int RWSC_CA_OSC = 3;
	localparam int RWSC_CA_POR = 1;
	localparam int RWSC_CA_BOD = 0;
	localparam int RWSC_IC_GIE = 7;
	localparam int RWSC_IC_PEIE = 6;
	localparam int RWSC_PF_CMP = 6;
	localparam logic [7:0] RWSC_PF_IMPL = 8'hf7;
	localparam logic [7:0] RWSC_STATUS_POR = 8'h18;
	localparam logic [7:0] RWSC_CAUSE_POR = 8'h09;
	localparam logic [7:0] RWSC_ZERO8 = 8'h00;
	localparam logic [2:0] RWSC_ZERO3 = 3'h0;
	localparam int RWSC_PC_W = 13;
	localparam logic [12:0] RWSC_PC_RESET = 13'h0000;
	localparam logic [12:0] RWSC_PC_VECTOR = 13'h0004;

	// Event bits of the interrupt status register
	localparam int RWSC_NEV = 4;
	localparam int RWSC_EV_RESET = 0;
	localparam int RWSC_EV_SLEEP = 1;
	localparam int RWSC_EV_WWDT = 2;
	localparam int RWSC_EV_WIRQ = 3;

	// ------------------------------------------------------------
	// Types; causes are in rising order of priority
	// ------------------------------------------------------------
	typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_SLEEP, ST_STEP} rwsc_state_e;
	typedef enum logic [2:0] {
		CS_NONE, CS_EXT_RUN, CS_EXT_SLEEP, CS_WDT, CS_BOR, CS_POR
	} rwsc_cause_e;

endpackage

// ---- verilog/rwsc_pin_sync.sv ----
/*
 * Three-stage pin synchroniser with agreement filter, one lane per bit.
 * Assumes inputs come from pins or analog detectors, asynchronous to i_clk_sys.
 */
`timescale 1ns/1ps
module rwsc_pin_sync #(
	parameter int W = 2,
	parameter logic [1:0] INIT = 2'h0
) (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);

	// ------------------------------------------------------------
	// Per-bit chain; output follows once stages two and three agree
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_lane
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic out_q;
			// Stage one feeds stage two only
			always_ff @(posedge i_clk_sys or negedge i_resetn) begin
				if (!i_resetn) begin
					s1_q <= INIT[g];
					s2_q <= INIT[g];
					s3_q <= INIT[g];
					out_q <= INIT[g];
				end else begin
					s1_q <= i_async[g];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						out_q <= s3_q;
					end
				end
			end
			assign o_sync[g] = out_q;
		end
	endgenerate

endmodule

// ---- verilog/rwsc_top.sv ----
/*
 * Reset and sleep/wake state control of a small 8-bit core: reset hold,
 * program counter loads, status and reset-cause flags, interrupt flags,
 * sleep entry and wake-up.
 * Assumes the core pulses i_sleep_exec when it executes sleep and
 * i_instr_done when an instruction retires; pins are asynchronous.
 */
// Notes on behaviour
// - Every reset source ends with the program counter loaded with zero.
// - Pin reset in sleep: upper status bits cleared, timeout set, power-down cleared.
// - Interrupt wake continues after sleep, sets timeout, clears power-down.
// - Interrupt wake with global enable: run next instruction, then vector four.
// - Watchdog expiry in sleep wakes without reset, clears timeout and power-down.
// - Brown-out reset clears cause bit 0; power-on reset sets it; other resets keep it.
// - Comparator wake sets peripheral flag bit 6; others leave it.
// - An interrupt wake always has a pending flag showing its source.
// - Sleep clears power-down flag and sets timeout flag.
// - Sleep clears the watchdog counter and its prescaler.
// - After sleep the clock stops until reset, watchdog or enabled interrupt.
`timescale 1ns/1ps
module rwsc_top
	import rwsc_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic i_ext_reset_pin_n,
	input wire logic i_brownout,
	input wire logic i_wdt_expire,
	input wire logic i_sleep_exec,
	input wire logic i_instr_done,
	input wire logic [2:0] i_int_events,
	input wire logic [7:0] i_periph_events,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic o_core_reset,
	output logic o_core_clk_en,
	output logic o_pc_load,
	output logic [RWSC_PC_W-1:0] o_pc_value,
	output logic o_wdt_clear,
	output logic o_irq
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	rwsc_state_e state_q, state_d;
	rwsc_cause_e cause_q, src_cause;
	logic [1:0] pins_sync;
	logic ext_rst, bor_rst, any_src, rel, slp_go, wake_wdt, wake_irq, irq_pend;
	logic [7:0] status_q, rcause_q, intctl_q, pflag_q, pen_q, rdata_q;
	logic [RWSC_NEV-1:0] evstat_q, evmask_q, ev;
	logic core_reset_q, clk_en_q, pc_load_q, wdt_clear_q, irq_q;
	logic [RWSC_PC_W-1:0] pc_value_q;

	// ------------------------------------------------------------
	// Pin inputs: pin level 0 is reset; brown-out detector high is reset
	// ------------------------------------------------------------
	rwsc_pin_sync #(
		.W(2),
		.INIT(2'h1)
	) rwsc_pin_sync_i (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_async({i_brownout, i_ext_reset_pin_n}),
		.o_sync(pins_sync)
	);
	assign ext_rst = ~pins_sync[0];
	assign bor_rst = pins_sync[1];

	// ------------------------------------------------------------
	// Reset sources and wake conditions
	// ------------------------------------------------------------
	// Watchdog expiry resets only while awake; asleep it wakes
	assign any_src = ext_rst | bor_rst | (i_wdt_expire & (state_q != ST_SLEEP));
	assign irq_pend = |(intctl_q[2:0] & intctl_q[5:3])
		| (intctl_q[RWSC_IC_PEIE] & |(pflag_q & pen_q));
	assign rel = (state_q == ST_HOLD) & ~any_src;
	assign slp_go = (state_q == ST_RUN) & ~any_src & i_sleep_exec;
	assign wake_wdt = (state_q == ST_SLEEP) & ~any_src & i_wdt_expire;
	assign wake_irq = (state_q == ST_SLEEP) & ~any_src & ~i_wdt_expire & irq_pend;

	// Highest-priority source active this cycle
	assign src_cause = bor_rst ? CS_BOR
		: (i_wdt_expire && state_q != ST_SLEEP) ? CS_WDT
		: !ext_rst ? CS_NONE
		: (state_q == ST_SLEEP) ? CS_EXT_SLEEP : CS_EXT_RUN;

	// Next state of the reset and sleep sequence
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_HOLD: state_d = any_src ? ST_HOLD : ST_RUN;
			ST_RUN: state_d = any_src ? ST_HOLD : (i_sleep_exec ? ST_SLEEP : ST_RUN);
			ST_SLEEP: begin
				if (any_src) begin
					state_d = ST_HOLD;
				end else if (wake_wdt) begin
					state_d = ST_RUN;
				end else if (wake_irq) begin
					state_d = intctl_q[RWSC_IC_GIE] ? ST_STEP : ST_RUN;
				end
			end
			ST_STEP: state_d = any_src ? ST_HOLD : (i_instr_done ? ST_RUN : ST_STEP);
			default: state_d = ST_HOLD;
		endcase
	end

	// State register; power-up comes from the asynchronous reset
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q <= ST_HOLD;
		end else begin
			state_q <= state_d;
		end
	end

	// Cause gathered while held, only the strongest kept
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			cause_q <= CS_POR;
		end else if (state_q != ST_HOLD && any_src) begin
			cause_q <= src_cause;
		end else if (state_q == ST_HOLD && src_cause > cause_q) begin
			cause_q <= src_cause;
		end
	end

	// ------------------------------------------------------------
	// Core control outputs
	// ------------------------------------------------------------
	// Hold and clock gate follow the next state; watchdog clear pulses on sleep entry
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			core_reset_q <= 1'b1;
			clk_en_q <= 1'b1;
			wdt_clear_q <= 1'b0;
		end else begin
			core_reset_q <= (state_d == ST_HOLD);
			clk_en_q <= (state_d != ST_SLEEP);
			wdt_clear_q <= slp_go;
		end
	end

	// Program counter loads: zero on release, vector after the step
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			pc_load_q <= 1'b0;
			pc_value_q <= RWSC_PC_RESET;
		end else begin
			pc_load_q <= 1'b0;
			if (rel) begin
				pc_load_q <= 1'b1;
				pc_value_q <= RWSC_PC_RESET;
			end else if (state_q == ST_STEP && !any_src && i_instr_done) begin
				pc_load_q <= 1'b1;
				pc_value_q <= RWSC_PC_VECTOR;
			end
		end
	end

	// ------------------------------------------------------------
	// Status register: timeout and power-down are hardware owned
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			status_q <= RWSC_STATUS_POR;
		end else if (rel) begin
			status_q[7:5] <= RWSC_ZERO3;
			case (cause_q)
				CS_POR: begin
					status_q <= RWSC_STATUS_POR;
				end
				CS_EXT_SLEEP: begin
					status_q[RWSC_ST_TO] <= 1'b1;
					status_q[RWSC_ST_PD] <= 1'b0;
				end
				CS_WDT: begin
					status_q[RWSC_ST_TO] <= 1'b0;
					status_q[RWSC_ST_PD] <= 1'b0;
				end
				CS_BOR: begin
					status_q[RWSC_ST_TO] <= 1'b1;
					status_q[RWSC_ST_PD] <= 1'b1;
				end
				default: begin
				end
			endcase
		end else if (slp_go || wake_irq) begin
			status_q[RWSC_ST_TO] <= 1'b1;
			status_q[RWSC_ST_PD] <= 1'b0;
		end else if (wake_wdt) begin
			status_q[RWSC_ST_TO] <= 1'b0;
			status_q[RWSC_ST_PD] <= 1'b0;
		end else if (i_wr && i_addr == RWSC_ADDR_STATUS) begin
			status_q[7:5] <= i_wdata[7:5];
			status_q[2:0] <= i_wdata[2:0];
		end
	end

	// Reset-cause register; software may set its two cause bits
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			rcause_q <= RWSC_CAUSE_POR;
		end else if (rel) begin
			rcause_q[RWSC_CA_OSC] <= 1'b1;
			if (cause_q == CS_POR) begin
				rcause_q <= RWSC_CAUSE_POR;
			end else if (cause_q == CS_BOR) begin
				rcause_q[RWSC_CA_BOD] <= 1'b0;
			end
		end else if (i_wr && i_addr == RWSC_ADDR_CAUSE) begin
			rcause_q[RWSC_CA_POR] <= i_wdata[RWSC_CA_POR];
			rcause_q[RWSC_CA_BOD] <= i_wdata[RWSC_CA_BOD];
		end
	end

	// ------------------------------------------------------------
	// Interrupt flags and enables; an event beats a clearing write
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			intctl_q <= RWSC_ZERO8;
		end else if (rel) begin
			intctl_q[7:1] <= RWSC_ZERO8[7:1];
		end else begin
			if (i_wr && i_addr == RWSC_ADDR_INTCTL) begin
				intctl_q <= i_wdata | {5'h00, i_int_events};
			end else begin
				intctl_q[2:0] <= intctl_q[2:0] | i_int_events;
			end
		end
	end

	// Peripheral flags; comparator change sets its own bit only
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			pflag_q <= RWSC_ZERO8;
		end else if (rel) begin
			pflag_q <= RWSC_ZERO8;
		end else if (i_wr && i_addr == RWSC_ADDR_PFLAG) begin
			pflag_q <= (i_wdata | i_periph_events) & RWSC_PF_IMPL;
		end else begin
			pflag_q <= (pflag_q | i_periph_events) & RWSC_PF_IMPL;
		end
	end

	// Peripheral enables
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			pen_q <= RWSC_ZERO8;
		end else if (rel) begin
			pen_q <= RWSC_ZERO8;
		end else if (i_wr && i_addr == RWSC_ADDR_PEN) begin
			pen_q <= i_wdata & RWSC_PF_IMPL;
		end
	end

	// ------------------------------------------------------------
	// Event status, read to clear, and masked interrupt line
	// ------------------------------------------------------------
	assign ev = {wake_irq, wake_wdt, slp_go, rel};

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			evstat_q <= '0;
			evmask_q <= '0;
			irq_q <= 1'b0;
		end else begin
			if (i_rd && i_addr == RWSC_ADDR_EVSTAT) begin
				evstat_q <= ev;
			end else begin
				evstat_q <= evstat_q | ev;
			end
			if (i_wr && i_addr == RWSC_ADDR_EVMASK) begin
				evmask_q <= i_wdata[RWSC_NEV-1:0];
			end
			irq_q <= |(evstat_q & evmask_q);
		end
	end

	// ------------------------------------------------------------
	// Read data, one cycle after the strobe; unmapped reads zero
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata_q <= RWSC_ZERO8;
		end else if (i_rd) begin
			case (i_addr)
				RWSC_ADDR_STATUS: rdata_q <= status_q;
				RWSC_ADDR_CAUSE: rdata_q <= rcause_q;
				RWSC_ADDR_INTCTL: rdata_q <= intctl_q;
				RWSC_ADDR_PFLAG: rdata_q <= pflag_q;
				RWSC_ADDR_PEN: rdata_q <= pen_q;
				RWSC_ADDR_EVSTAT: rdata_q <= {4'h0, evstat_q};
				RWSC_ADDR_EVMASK: rdata_q <= {4'h0, evmask_q};
				default: rdata_q <= RWSC_ZERO8;
			endcase
		end else begin
			rdata_q <= RWSC_ZERO8;
		end
	end

	assign o_rdata = rdata_q;
	assign o_core_reset = core_reset_q;
	assign o_core_clk_en = clk_en_q;
	assign o_pc_load = pc_load_q;
	assign o_pc_value = pc_value_q;
	assign o_wdt_clear = wdt_clear_q;
	assign o_irq = irq_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_resetn);

	chk_pc_zero_load: assert property (rel |=> o_pc_load && o_pc_value == RWSC_PC_RESET)
		else $error("reset release did not load pc zero");
	chk_ext_sleep_status: assert property (
		rel && cause_q == CS_EXT_SLEEP |=> status_q[7:3] == 5'h02
			&& status_q[2:0] == $past(status_q[2:0]))
		else $error("pin reset in sleep left wrong status");
	chk_irq_wake_cont: assert property (
		wake_irq |=> !o_pc_load && status_q[RWSC_ST_TO] && !status_q[RWSC_ST_PD] && o_core_clk_en)
		else $error("interrupt wake did not continue with right flags");
	chk_vector_after_step: assert property (
		state_q == ST_STEP && !any_src && i_instr_done
			|=> o_pc_load && o_pc_value == RWSC_PC_VECTOR)
		else $error("no vector load after the wake step");
	chk_wdt_wake_flags: assert property (
		wake_wdt |=> !status_q[RWSC_ST_TO] && !status_q[RWSC_ST_PD]
			&& !o_core_reset && !o_pc_load && o_core_clk_en)
		else $error("watchdog wake handled as reset or wrong flags");
	chk_bor_cause_bit: assert property (
		rel |=> rcause_q[RWSC_CA_BOD] == (($past(cause_q) == CS_BOR) ? 1'b0
			: ($past(cause_q) == CS_POR) ? 1'b1 : $past(rcause_q[RWSC_CA_BOD])))
		else $error("brown-out cause bit wrong after reset");
	chk_cmp_flag_set: assert property (
		!rel && i_periph_events[RWSC_PF_CMP] |=> pflag_q[RWSC_PF_CMP])
		else $error("comparator event lost");
	chk_wake_has_flag: assert property (
		wake_irq |=> (|intctl_q[2:0]) || (|pflag_q))
		else $error("interrupt wake with no pending flag");
	chk_sleep_flags: assert property (
		slp_go |=> status_q[RWSC_ST_TO] && !status_q[RWSC_ST_PD])
		else $error("sleep left wrong status flags");
	chk_sleep_wdt_clr: assert property (
		slp_go |=> o_wdt_clear ##1 !o_wdt_clear)
		else $error("sleep did not pulse watchdog clear");
	chk_sleep_clock_off: assert property (
		state_q == ST_SLEEP && !any_src && !i_wdt_expire && !irq_pend |=> !o_core_clk_en)
		else $error("clock running in sleep with no wake cause");
	chk_hold_all_sources: assert property (
		any_src |=> o_core_reset && !o_pc_load)
		else $error("core released while a reset source is active");

	cov_reset_then_sleep: cover property (rel ##[1:20] slp_go);
	cov_wdt_wake: cover property (wake_wdt);
	cov_irq_vector: cover property (state_q == ST_STEP ##1 o_pc_load);
	cov_ext_in_sleep: cover property (state_q == ST_SLEEP && ext_rst);

endmodule

// ---- tb/rwsc_top_tb_top.sv ----
/*
 * Self-checking bench of rwsc_top: register port, sleep, wake and reset scenarios.
 * Assumes the design package, a 100 MHz core clock and released pins at start.
 */
`timescale 1ns/1ps
module rwsc_top_tb_top
	import rwsc_pkg::*;
;
	logic i_clk_sys = 1'b0;
	logic i_resetn = 1'b0;
	logic i_ext_reset_pin_n = 1'b1;
	logic i_brownout = 1'b0, i_wdt_expire = 1'b0, i_sleep_exec = 1'b0, i_instr_done = 1'b0;
	logic i_wr = 1'b0, i_rd = 1'b0;
	logic [2:0] i_int_events = 3'h0;
	logic [7:0] i_periph_events = 8'h00, i_addr = 8'h00, i_wdata = 8'h00;
	logic [7:0] o_rdata;
	logic o_core_reset, o_core_clk_en, o_pc_load, o_wdt_clear, o_irq;
	logic [RWSC_PC_W-1:0] o_pc_value;
	logic [7:0] exp_rd[$];
	logic [RWSC_PC_W-1:0] exp_pc[$];
	logic rd_q = 1'b0;
	logic [31:0] seed = 32'h479d1e6b;
	logic [7:0] sw, pb, keep;
	int n_fail = 0;
	int compares = 0;

	rwsc_top rwsc_top_i (.i_clk_sys, .i_resetn, .i_ext_reset_pin_n, .i_brownout,
		.i_wdt_expire, .i_sleep_exec, .i_instr_done, .i_int_events, .i_periph_events,
		.i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_core_reset, .o_core_clk_en,
		.o_pc_load, .o_pc_value, .o_wdt_clear, .o_irq);

	// Core clock, 10 ns period
	always #5 i_clk_sys = ~i_clk_sys;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task end_of_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Result watcher: read data and program counter loads against the notes
	always @(posedge i_clk_sys) begin
		if (rd_q) begin
			if (exp_rd.size() == 0) chk("rdata_note", 16'h1, 16'h0);
			else chk("rdata", 16'(exp_rd.pop_front()), 16'(o_rdata));
		end
		if (o_pc_load === 1'b1) begin
			if (exp_pc.size() == 0) chk("pc_load_note", 16'h1, 16'h0);
			else chk("pc_value", 16'(exp_pc.pop_front()), 16'(o_pc_value));
		end
		rd_q <= i_rd;
	end

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clk_sys);
		i_rd <= 1'b1;
		i_addr <= a;
		exp_rd.push_back(e);
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
	endtask

	// One-cycle pulse: 0 sleep, 1 watchdog, 2 core events, 3 peripheral events, 4 retire
	task pulse(input int w, input logic [7:0] v);
		@(posedge i_clk_sys);
		case (w)
			0: i_sleep_exec <= 1'b1;
			1: i_wdt_expire <= 1'b1;
			2: i_int_events <= v[2:0];
			3: i_periph_events <= v;
			default: i_instr_done <= 1'b1;
		endcase
		@(posedge i_clk_sys);
		i_sleep_exec <= 1'b0;
		i_wdt_expire <= 1'b0;
		i_int_events <= 3'h0;
		i_periph_events <= 8'h00;
		i_instr_done <= 1'b0;
	endtask

	function automatic logic sig(input int w);
		return (w == 0) ? o_core_reset : (w == 1) ? o_core_clk_en : o_irq;
	endfunction

	// Bounded wait for a level output: 0 core reset, 1 clock enable, 2 interrupt
	task automatic wait_for(input int w, input logic v);
		for (int i = 0; i < 8; i++) begin
			if (sig(w) === v) break;
			@(posedge i_clk_sys);
			#1;
		end
	endtask

	task sleep_now;
		pulse(0, 8'h00);
		#1;
		chk("clk_en", 16'h0, 16'(o_core_clk_en));
		chk("wdt_clear", 16'h1, 16'(o_wdt_clear));
	endtask

	// Reset sources as a mask: bit0 pin, bit1 brown-out, bit2 watchdog
	task do_reset(input logic [2:0] k);
		exp_pc.push_back(RWSC_PC_RESET);
		@(posedge i_clk_sys);
		i_ext_reset_pin_n <= ~k[0];
		i_brownout <= k[1];
		i_wdt_expire <= k[2];
		wait_for(0, 1'b1);
		chk("core_reset", 16'h1, 16'(o_core_reset));
		if (k == 3'h3) begin
			@(posedge i_clk_sys);
			i_ext_reset_pin_n <= 1'b1;
			repeat (8) @(posedge i_clk_sys);
			#1;
			chk("core_reset", 16'h1, 16'(o_core_reset));
		end
		@(posedge i_clk_sys);
		i_ext_reset_pin_n <= 1'b1;
		i_brownout <= 1'b0;
		i_wdt_expire <= 1'b0;
		wait_for(0, 1'b0);
		chk("core_reset", 16'h0, 16'(o_core_reset));
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		exp_pc.push_back(RWSC_PC_RESET);
		repeat (20) @(posedge i_clk_sys);
		i_resetn <= 1'b1;
		rd(RWSC_ADDR_STATUS, RWSC_STATUS_POR);
		rd(RWSC_ADDR_CAUSE, RWSC_CAUSE_POR);
		rd(8'h55, 8'h00);
		#1;
		chk("irq_masked", 16'h0, 16'(o_irq));
		rd(RWSC_ADDR_EVSTAT, 8'h01);
		seed = lfsr(seed);
		wr(RWSC_ADDR_STATUS, seed[7:0]);
		sw = seed[7:0] & 8'he7;
		rd(RWSC_ADDR_STATUS, sw | 8'h18);
		wr(RWSC_ADDR_EVMASK, 8'h02);
		sleep_now;
		rd(RWSC_ADDR_STATUS, sw | 8'h10);
		wait_for(2, 1'b1);
		chk("irq", 16'h1, 16'(o_irq));
		repeat (5) @(posedge i_clk_sys);
		#1;
		chk("clk_en", 16'h0, 16'(o_core_clk_en));
		pulse(1, 8'h00);
		#1;
		chk("clk_en", 16'h1, 16'(o_core_clk_en));
		chk("core_reset", 16'h0, 16'(o_core_reset));
		rd(RWSC_ADDR_STATUS, sw);
		rd(RWSC_ADDR_CAUSE, 8'h09);
		rd(RWSC_ADDR_EVSTAT, 8'h06);
		wait_for(2, 1'b0);
		chk("irq", 16'h0, 16'(o_irq));
		// Watchdog reset, pin reset running, pin reset asleep, brown-out, combined
		do_reset(3'h4);
		rd(RWSC_ADDR_STATUS, sw & 8'h07);
		rd(RWSC_ADDR_CAUSE, 8'h09);
		wr(RWSC_ADDR_STATUS, 8'he5);
		do_reset(3'h1);
		rd(RWSC_ADDR_STATUS, 8'h05);
		wr(RWSC_ADDR_STATUS, 8'he6);
		sleep_now;
		do_reset(3'h1);
		rd(RWSC_ADDR_STATUS, 8'h16);
		rd(RWSC_ADDR_CAUSE, 8'h09);
		chk("clk_en", 16'h1, 16'(o_core_clk_en));
		do_reset(3'h2);
		rd(RWSC_ADDR_STATUS, 8'h1e);
		rd(RWSC_ADDR_CAUSE, 8'h08);
		wr(RWSC_ADDR_CAUSE, 8'h01);
		rd(RWSC_ADDR_CAUSE, 8'h09);
		do_reset(3'h3);
		rd(RWSC_ADDR_CAUSE, 8'h08);
		// Interrupt wake with global enable, then vector load
		wr(RWSC_ADDR_INTCTL, 8'h88);
		sleep_now;
		pulse(2, 8'h01);
		wait_for(1, 1'b1);
		chk("clk_en", 16'h1, 16'(o_core_clk_en));
		rd(RWSC_ADDR_STATUS, 8'h16);
		rd(RWSC_ADDR_INTCTL, 8'h89);
		exp_pc.push_back(RWSC_PC_VECTOR);
		pulse(4, 8'h00);
		repeat (3) @(posedge i_clk_sys);
		wr(RWSC_ADDR_INTCTL, 8'h00);
		// Peripheral wakes without global enable: comparator, then another source
		for (int b = 0; b < 2; b++) begin
			pb = (b == 0) ? 8'h40 : 8'h01;
			keep = (b == 0) ? 8'h00 : 8'h40;
			wr(RWSC_ADDR_PFLAG, keep);
			wr(RWSC_ADDR_PEN, pb);
			wr(RWSC_ADDR_INTCTL, 8'h40);
			sleep_now;
			pulse(3, pb);
			wait_for(1, 1'b1);
			chk("clk_en", 16'h1, 16'(o_core_clk_en));
			rd(RWSC_ADDR_PFLAG, keep | pb);
			pulse(4, 8'h00);
			repeat (3) @(posedge i_clk_sys);
		end
		chk("pc_loads_left", 16'h0, 16'(exp_pc.size()));
		end_of_test;
	end

	// Hang guard, far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		n_fail++;
		end_of_test;
	end
endmodule
